// *** hdl/rms_pkg.sv ***
// shared constants and types for the relay matrix command sequencer
package rms_pkg;
    localparam int NUM_SLOT = 4;
    localparam int SLOT_W = 2;
    localparam int REL_W = 8;
    localparam int ENT_W = SLOT_W + REL_W;
    localparam int RELAY_N = NUM_SLOT * (2 ** REL_W);
    localparam int LABEL_W = 16;
    localparam int SCAN_DEPTH = 64;
    localparam int SCAN_AW = 6;
    localparam int SCAN_CW = 7;
    localparam int TTL_N = 8;
    localparam int TTL_SW = 3;
    localparam int TIME_W = 16;
    localparam int NUM_W = 10;
    // selector arithmetic
    localparam logic [NUM_W-1:0] SEC_SPAN = 10'h040;
    localparam logic [NUM_W-1:0] ROW_SPAN = 10'h010;
    localparam logic [NUM_W-1:0] DEC_BASE = 10'h00a;
    localparam logic [NUM_W-1:0] ONE = 10'h001;
    // ascii
    localparam logic [7:0] CH_BANG = 8'h21;
    localparam logic [7:0] CH_COLON = 8'h3a;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_LPAR = 8'h28;
    localparam logic [7:0] CH_RPAR = 8'h29;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_M = 8'h6d;
    localparam logic [7:0] CH_ONE = 8'h31;
    // timing at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int PULSE_NS = 3000;
    localparam int PULSE_CYC = PULSE_NS * CLK_MHZ / 1000;
    localparam int DWELL_UNIT_US = 100;
    localparam int DWELL_UNIT_CYC = DWELL_UNIT_US * CLK_MHZ;
    localparam int TICK_W = 14;
    localparam int PCNT_W = 9;
    // commands
    localparam logic [3:0] CMD_ABORT = 4'h0;
    localparam logic [3:0] CMD_ARM = 4'h1;
    localparam logic [3:0] CMD_TRG_BUS = 4'h2;
    localparam logic [3:0] CMD_TRG_COMMON = 4'h3;
    localparam logic [3:0] CMD_TRG_IMM = 4'h4;
    localparam logic [3:0] CMD_CLOSE = 4'h5;
    localparam logic [3:0] CMD_QUERY = 4'h6;
    localparam logic [3:0] CMD_SCAN = 4'h7;
    localparam logic [3:0] CMD_RESET = 4'h8;
    localparam logic [3:0] CMD_SRC = 4'h9;
    localparam logic [3:0] CMD_CDWELL = 4'ha;
    localparam logic [3:0] CMD_ODWELL = 4'hb;
    localparam logic [3:0] CMD_TDELAY = 4'hc;
    localparam logic [3:0] CMD_TTL_EN = 4'hd;
    localparam logic [3:0] CMD_DEFINE = 4'he;
    // trigger sources
    localparam logic [1:0] SRC_HOLD = 2'h0;
    localparam logic [1:0] SRC_BUS = 2'h1;
    localparam logic [1:0] SRC_IMM = 2'h2;
    localparam logic [1:0] SRC_TTL = 2'h3;
    localparam int TTL_EN_BIT = 3;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_LIST = 6'h02,
        ST_DELAY = 6'h04,
        ST_ODWELL = 6'h08,
        ST_CDWELL = 6'h10,
        ST_PULSE = 6'h20
    } rms_state_e;
endpackage

// *** hdl/rms_chan_parse.sv ***
// channel list text parser: labels, selectors and ranges to relay indices
`timescale 1ns/1ps
module rms_chan_parse (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ch_valid,
    input wire logic [7:0] ch_data,
    input wire logic [rms_pkg::NUM_SLOT*rms_pkg::LABEL_W-1:0] labels,
    output logic ch_ready,
    output logic rel_valid,
    output logic [rms_pkg::ENT_W-1:0] rel_ent,
    output logic list_done
);
    typedef struct packed {
        logic in_list;
        logic [rms_pkg::LABEL_W-1:0] lab;
        logic [rms_pkg::SLOT_W-1:0] slot;
        logic slot_ok;
        logic [rms_pkg::NUM_W-1:0] num;
        logic [rms_pkg::NUM_W-1:0] f0;
        logic [rms_pkg::NUM_W-1:0] f1;
        logic [1:0] parts;
        logic have_lo;
        logic [rms_pkg::REL_W-1:0] cur;
        logic [rms_pkg::REL_W-1:0] hi;
        logic expand;
        logic ready;
        logic rel_valid;
        logic [rms_pkg::REL_W-1:0] rel_idx;
        logic done;
    } rms_parse_s;

    rms_parse_s r;
    rms_parse_s n;

    function automatic logic [rms_pkg::REL_W-1:0] spec_idx(input logic [1:0] parts,
            input logic [rms_pkg::NUM_W-1:0] f0, input logic [rms_pkg::NUM_W-1:0] f1,
            input logic [rms_pkg::NUM_W-1:0] num);
        logic [rms_pkg::NUM_W-1:0] v;
        case (parts)
            2'h0: v = num; // R11
            2'h1: v = 10'((f0 - rms_pkg::ONE) * rms_pkg::ROW_SPAN + num); // R10
            default: v = 10'((num - rms_pkg::ONE) * rms_pkg::SEC_SPAN + (f0 - rms_pkg::ONE) * rms_pkg::ROW_SPAN + f1); // R09
        endcase
        return 8'(v - rms_pkg::ONE);
    endfunction

    logic [rms_pkg::REL_W-1:0] spec;
    assign spec = spec_idx(r.parts, r.f0, r.f1, r.num);

    always_comb begin
        n = r;
        n.rel_valid = 1'b0;
        n.done = 1'b0;
        if (r.expand) begin
            // one relay per cycle; char input stalls meanwhile
            n.rel_valid = r.slot_ok;
            n.rel_idx = r.cur;
            n.cur = 8'(r.cur + 8'h01); // R20
            n.expand = (r.cur != r.hi);
        end else if (ch_valid) begin
            if (!r.in_list) begin
                if (ch_data == rms_pkg::CH_LPAR) begin
                    n.in_list = 1'b1;
                    n.slot_ok = 1'b0;
                    for (int i = 0; i < rms_pkg::NUM_SLOT; i++) begin
                        if (labels[i*rms_pkg::LABEL_W +: rms_pkg::LABEL_W] == r.lab) begin // R12
                            n.slot = 2'(i);
                            n.slot_ok = 1'b1;
                        end
                    end
                    n.num = '0;
                    n.parts = 2'h0;
                    n.have_lo = 1'b0;
                end else if (ch_data == rms_pkg::CH_LF) begin
                    n.done = 1'b1;
                    n.lab = '0;
                end else if (ch_data != rms_pkg::CH_COMMA) begin
                    n.lab = {r.lab[7:0], ch_data};
                end
            end else if (ch_data >= rms_pkg::CH_ZERO && ch_data <= rms_pkg::CH_NINE) begin
                n.num = 10'(r.num * rms_pkg::DEC_BASE + 10'(ch_data - rms_pkg::CH_ZERO));
            end else if (ch_data == rms_pkg::CH_BANG) begin
                if (r.parts == 2'h0) begin
                    n.f0 = r.num;
                end else begin
                    n.f1 = r.num;
                end
                n.parts = 2'(r.parts + 2'h1);
                n.num = '0;
            end else if (ch_data == rms_pkg::CH_COLON) begin // R08
                n.cur = spec;
                n.have_lo = 1'b1;
                n.parts = 2'h0;
                n.num = '0;
            end else if (ch_data == rms_pkg::CH_COMMA || ch_data == rms_pkg::CH_RPAR) begin
                if (r.have_lo) begin
                    n.hi = spec; // R20
                    n.expand = 1'b1;
                end else begin
                    n.rel_valid = r.slot_ok;
                    n.rel_idx = spec;
                end
                n.have_lo = 1'b0;
                n.parts = 2'h0;
                n.num = '0;
                if (ch_data == rms_pkg::CH_RPAR) begin
                    n.in_list = 1'b0;
                    n.lab = '0;
                end
            end
        end
        n.ready = !n.expand;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= '0;
            r.ready <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign ch_ready = r.ready;
    assign rel_valid = r.rel_valid;
    assign rel_ent = {r.slot, r.rel_idx};
    assign list_done = r.done;
endmodule // rms_chan_parse

// *** hdl/rms_seq.sv ***
// relay matrix command sequencer: close, query, scan, settle and trigger pulses
// Notes on behaviour
// (R01) abort returns an armed scan to idle
// (R02) after abort triggers ignored until re-armed
// (R03) hold source rejects ttl, bus, common triggers
// (R04) explicit immediate trigger advances, skips delay
// (R05) first trigger closes first; later open-then-close
// (R06) reset command opens every relay
// (R07) query reports closed state per selector
// (R08) list element is selector or colon range
// (R09) three-part selector is row, column, section
// (R10) two-part selector is row, column, section one
// (R11) single integer maps by section/row/column formula
// (R12) selectors qualified by bound module label
// (R13) default labels m1, m2, ... by slot
// (R14) wait module close settle after closing
// (R15) several modules: wait longest close settle
// (R16) then pulse enabled trigger lines low 3 us
// (R17) disabled lines excluded from later pulses
// (R18) settle time 0 to 6.5535 s, resets 0
// (R19) trigger: delay, open, settle, close, settle, pulse
// (R20) range expands ascending, both ends inclusive
`timescale 1ns/1ps
module rms_seq #(
    parameter int unsigned DWELL_UNIT_CYC = rms_pkg::DWELL_UNIT_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_op,
    input wire logic [rms_pkg::SLOT_W-1:0] cmd_slot,
    input wire logic [rms_pkg::TIME_W-1:0] cmd_arg,
    output logic cmd_ready,
    input wire logic chr_valid,
    input wire logic [7:0] chr_data,
    output logic chr_ready,
    input wire logic [rms_pkg::TTL_N-1:0] ttl_in,
    output logic [rms_pkg::TTL_N-1:0] ttl_out_n,
    output logic [rms_pkg::RELAY_N-1:0] relay_closed,
    output logic q_valid,
    output logic q_closed,
    output logic scan_armed
);
    typedef struct packed {
        rms_pkg::rms_state_e state;
        logic [rms_pkg::RELAY_N-1:0] relay;
        logic [rms_pkg::NUM_SLOT-1:0][rms_pkg::LABEL_W-1:0] labels;
        logic [rms_pkg::NUM_SLOT-1:0][rms_pkg::TIME_W-1:0] cdwell;
        logic [rms_pkg::NUM_SLOT-1:0][rms_pkg::TIME_W-1:0] odwell;
        logic [rms_pkg::TIME_W-1:0] tdelay;
        logic [rms_pkg::TTL_N-1:0] ttl_en;
        logic [1:0] src;
        logic [rms_pkg::TTL_SW-1:0] ttl_sel;
        logic armed;
        logic [rms_pkg::SCAN_DEPTH-1:0][rms_pkg::ENT_W-1:0] scan_mem;
        logic [rms_pkg::SCAN_CW-1:0] scan_len;
        logic [rms_pkg::SCAN_CW-1:0] scan_pos;
        logic [3:0] list_op;
        logic [rms_pkg::TIME_W-1:0] max_dwell;
        logic [rms_pkg::TIME_W-1:0] units;
        logic [rms_pkg::TICK_W-1:0] tick;
        logic [rms_pkg::PCNT_W-1:0] pcnt;
        logic [rms_pkg::TTL_N-1:0] ttl_out_n;
        logic [rms_pkg::TTL_N-1:0] ttl_prev;
        logic cmd_ready;
        logic q_valid;
        logic q_closed;
    } rms_seq_s;

    rms_seq_s r;
    rms_seq_s n;

    logic p_ready;
    logic rel_valid;
    logic [rms_pkg::ENT_W-1:0] rel_ent;
    logic list_done;

    // chars outside a list command are dropped, so the parser never sees stray text
    rms_chan_parse u_parse (
        .clk(clk),
        .sys_rst(sys_rst),
        .ch_valid(chr_valid && p_ready && r.state == rms_pkg::ST_LIST),
        .ch_data(chr_data),
        .labels(r.labels),
        .ch_ready(p_ready),
        .rel_valid(rel_valid),
        .rel_ent(rel_ent),
        .list_done(list_done)
    );

    logic take;
    logic idle;
    logic ttl_fall;
    logic go;
    logic trig;
    logic explicit_trg;
    logic wait_done;
    logic [rms_pkg::ENT_W-1:0] cur_ent;
    logic [rms_pkg::ENT_W-1:0] prev_ent;

    assign idle = r.state == rms_pkg::ST_IDLE;
    // abort is taken in any state except while a list streams in
    assign take = cmd_valid && (idle || (cmd_op == rms_pkg::CMD_ABORT && r.state != rms_pkg::ST_LIST));
    assign explicit_trg = take && cmd_op == rms_pkg::CMD_TRG_IMM;
    assign ttl_fall = r.ttl_prev[r.ttl_sel] && !ttl_in[r.ttl_sel];
    assign go = explicit_trg // R04
        || (r.src == rms_pkg::SRC_BUS && take && (cmd_op == rms_pkg::CMD_TRG_BUS || cmd_op == rms_pkg::CMD_TRG_COMMON))
        || (r.src == rms_pkg::SRC_TTL && ttl_fall)
        || r.src == rms_pkg::SRC_IMM; // R03
    assign trig = r.armed && idle && r.scan_len != '0 && go; // R02
    assign wait_done = r.units == '0;
    assign cur_ent = r.scan_mem[r.scan_pos[rms_pkg::SCAN_AW-1:0]];
    assign prev_ent = r.scan_mem[6'(r.scan_pos - 7'h01)];

    always_comb begin
        n = r;
        n.q_valid = 1'b0;
        n.ttl_prev = ttl_in;
        if (!wait_done) begin
            if (r.tick == 14'(DWELL_UNIT_CYC - 1)) begin
                n.tick = '0;
                n.units = 16'(r.units - 16'h0001);
            end else begin
                n.tick = 14'(r.tick + 14'h0001);
            end
        end
        case (r.state)
            rms_pkg::ST_IDLE: begin
                if (trig) begin
                    n.state = rms_pkg::ST_DELAY; // R19
                    n.units = explicit_trg ? '0 : r.tdelay; // R04
                    n.tick = '0;
                end else if (take) begin
                    case (cmd_op)
                        rms_pkg::CMD_ARM: begin
                            n.armed = 1'b1;
                            n.scan_pos = '0;
                        end
                        rms_pkg::CMD_CLOSE, rms_pkg::CMD_QUERY, rms_pkg::CMD_SCAN: begin
                            n.state = rms_pkg::ST_LIST;
                            n.list_op = cmd_op;
                            n.max_dwell = '0;
                            if (cmd_op == rms_pkg::CMD_SCAN) begin
                                n.scan_len = '0;
                                n.scan_pos = '0;
                                n.armed = 1'b0;
                            end
                        end
                        rms_pkg::CMD_RESET: begin
                            n.relay = '0; // R06
                            n.cdwell = '0; // R18
                            n.odwell = '0;
                            n.tdelay = '0;
                            n.armed = 1'b0;
                            n.scan_pos = '0;
                        end
                        rms_pkg::CMD_SRC: begin
                            n.src = cmd_arg[1:0];
                            n.ttl_sel = cmd_arg[rms_pkg::TTL_SW+1:2];
                        end
                        rms_pkg::CMD_CDWELL: n.cdwell[cmd_slot] = cmd_arg; // R18
                        rms_pkg::CMD_ODWELL: n.odwell[cmd_slot] = cmd_arg;
                        rms_pkg::CMD_TDELAY: n.tdelay = cmd_arg;
                        rms_pkg::CMD_TTL_EN: n.ttl_en[cmd_arg[rms_pkg::TTL_SW-1:0]] = cmd_arg[rms_pkg::TTL_EN_BIT]; // R17
                        rms_pkg::CMD_DEFINE: n.labels[cmd_slot] = cmd_arg; // R12
                        default: begin
                        end
                    endcase
                end
            end
            rms_pkg::ST_LIST: begin
                if (rel_valid) begin
                    case (r.list_op)
                        rms_pkg::CMD_CLOSE: begin
                            n.relay[rel_ent] = 1'b1;
                            if (r.cdwell[rel_ent[rms_pkg::ENT_W-1:rms_pkg::REL_W]] > n.max_dwell) begin
                                n.max_dwell = r.cdwell[rel_ent[rms_pkg::ENT_W-1:rms_pkg::REL_W]]; // R15
                            end
                        end
                        rms_pkg::CMD_QUERY: begin
                            n.q_valid = 1'b1;
                            n.q_closed = r.relay[rel_ent]; // R07
                        end
                        default: begin
                            // entries beyond the list depth are dropped
                            if (r.scan_len != 7'(rms_pkg::SCAN_DEPTH)) begin
                                n.scan_mem[r.scan_len[rms_pkg::SCAN_AW-1:0]] = rel_ent;
                                n.scan_len = 7'(r.scan_len + 7'h01);
                            end
                        end
                    endcase
                end
                if (list_done) begin
                    if (r.list_op == rms_pkg::CMD_CLOSE) begin
                        n.state = rms_pkg::ST_CDWELL; // R14
                        n.units = n.max_dwell;
                        n.tick = '0;
                    end else begin
                        n.state = rms_pkg::ST_IDLE;
                    end
                end
            end
            rms_pkg::ST_DELAY: begin
                if (wait_done) begin
                    n.state = rms_pkg::ST_ODWELL;
                    n.tick = '0;
                    n.units = '0;
                    if (r.scan_pos != '0) begin
                        n.relay[prev_ent] = 1'b0; // R05
                        n.units = r.odwell[prev_ent[rms_pkg::ENT_W-1:rms_pkg::REL_W]];
                    end
                end
            end
            rms_pkg::ST_ODWELL: begin
                if (wait_done) begin
                    if (r.scan_pos == r.scan_len) begin
                        // list exhausted: nothing left to close
                        n.armed = 1'b0;
                        n.state = rms_pkg::ST_IDLE;
                    end else begin
                        n.relay[cur_ent] = 1'b1; // R05
                        n.scan_pos = 7'(r.scan_pos + 7'h01);
                        n.units = r.cdwell[cur_ent[rms_pkg::ENT_W-1:rms_pkg::REL_W]]; // R14
                        n.tick = '0;
                        n.state = rms_pkg::ST_CDWELL;
                    end
                end
            end
            rms_pkg::ST_CDWELL: begin
                if (wait_done) begin
                    n.state = rms_pkg::ST_PULSE;
                    n.ttl_out_n = ~r.ttl_en; // R16
                    n.pcnt = 9'(rms_pkg::PULSE_CYC - 1);
                end
            end
            rms_pkg::ST_PULSE: begin
                if (r.pcnt == '0) begin
                    n.ttl_out_n = '1;
                    n.state = rms_pkg::ST_IDLE;
                end else begin
                    n.pcnt = 9'(r.pcnt - 9'h001);
                end
            end
            default: n.state = rms_pkg::ST_IDLE;
        endcase
        if (take && cmd_op == rms_pkg::CMD_ABORT) begin
            n.armed = 1'b0; // R01
            n.state = rms_pkg::ST_IDLE;
            n.ttl_out_n = '1;
            n.units = '0;
        end
        n.cmd_ready = n.state == rms_pkg::ST_IDLE;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= '0;
            r.state <= rms_pkg::ST_IDLE;
            r.ttl_out_n <= '1;
            r.ttl_prev <= '1;
            r.cmd_ready <= 1'b1;
            for (int i = 0; i < rms_pkg::NUM_SLOT; i++) begin
                r.labels[i] <= {rms_pkg::CH_M, 8'(rms_pkg::CH_ONE + 8'(i))}; // R13
            end
        end else begin
            r <= n;
        end
    end

    assign cmd_ready = r.cmd_ready;
    assign chr_ready = p_ready;
    assign ttl_out_n = r.ttl_out_n;
    assign relay_closed = r.relay;
    assign q_valid = r.q_valid;
    assign q_closed = r.q_closed;
    assign scan_armed = r.armed;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic [rms_pkg::PCNT_W:0] low_run;
    always_ff @(posedge clk) begin
        if (sys_rst || r.state != rms_pkg::ST_PULSE) begin
            low_run <= '0;
        end else begin
            low_run <= 10'(low_run + 10'h001);
        end
    end

    sequence s_settle_end;
        r.state == rms_pkg::ST_CDWELL && wait_done && !(take && cmd_op == rms_pkg::CMD_ABORT);
    endsequence

    sequence s_pulse_start;
        r.state == rms_pkg::ST_PULSE && ttl_out_n == ~r.ttl_en;
    endsequence

    chk_abort_idle: assert property (take && cmd_op == rms_pkg::CMD_ABORT |=> !scan_armed && idle) // R01
        else $error("abort did not return scan to idle");
    chk_disarm_ignore: assert property (!r.armed && idle |=> r.state != rms_pkg::ST_DELAY) // R02
        else $error("trigger accepted while disarmed");
    chk_hold_reject: assert property (r.src == rms_pkg::SRC_HOLD && idle && !explicit_trg // R03
        |=> r.state != rms_pkg::ST_DELAY)
        else $error("trigger accepted under hold");
    chk_imm_skip: assert property (trig && explicit_trg |=> r.state == rms_pkg::ST_DELAY && wait_done) // R04
        else $error("explicit trigger did not skip delay");
    chk_reset_open: assert property (take && cmd_op == rms_pkg::CMD_RESET && !trig |=> relay_closed == '0) // R06
        else $error("reset left a relay closed");
    chk_query_state: assert property (r.state == rms_pkg::ST_LIST && rel_valid // R07
        && r.list_op == rms_pkg::CMD_QUERY |=> q_valid && q_closed == $past(relay_closed[rel_ent]))
        else $error("query reported wrong relay state");
    chk_settle_pulse: assert property (s_settle_end |=> s_pulse_start) // R14
        else $error("pulse did not follow settle");
    chk_pulse_width: assert property (r.state == rms_pkg::ST_PULSE && r.pcnt == '0 // R16
        |-> low_run == 10'(rms_pkg::PULSE_CYC - 1))
        else $error("trigger pulse width wrong");
    chk_pulse_mask: assert property ((~ttl_out_n & ~r.ttl_en) == '0 && (!idle || ttl_out_n == '1)) // R17
        else $error("disabled or idle trigger line driven low");
    chk_open_before_close: assert property (r.state == rms_pkg::ST_DELAY && wait_done && r.scan_pos != '0 // R19
        && !(take && cmd_op == rms_pkg::CMD_ABORT)
        |=> r.state == rms_pkg::ST_ODWELL && !relay_closed[$past(prev_ent)])
        else $error("current relay not opened first");
endmodule // rms_seq

// *** dv/rms_host.sv ***
// host model: command requests and channel-list text
`timescale 1ns/1ps
module rms_host (
    input wire logic clk,
    input wire logic cmd_ready,
    input wire logic chr_ready,
    output logic cmd_valid,
    output logic [3:0] cmd_op,
    output logic [rms_pkg::SLOT_W-1:0] cmd_slot,
    output logic [rms_pkg::TIME_W-1:0] cmd_arg,
    output logic chr_valid,
    output logic [7:0] chr_data,
    output logic [rms_pkg::TTL_N-1:0] ttl_in
);
    initial begin
        cmd_valid = 1'b0;
        cmd_op = 4'hf;
        cmd_slot = 2'h0;
        cmd_arg = 16'h0000;
        chr_valid = 1'b0;
        chr_data = 8'h00;
        ttl_in = 8'hff;
    end
    // one idle edge first so valid never toggles twice in a step
    task automatic cmd(input logic [3:0] op, input logic [1:0] slot, input logic [15:0] arg);
        @(negedge clk);
        while (!cmd_ready) @(negedge clk);
        cmd_op = op;
        cmd_slot = slot;
        cmd_arg = arg;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_op = ~op;
        cmd_arg = ~arg;
    endtask
    task automatic ttl(input logic [7:0] v);
        @(negedge clk);
        ttl_in = v;
    endtask
    task automatic list(input logic [3:0] op, input string s);
        cmd(op, 2'h0, 16'h0000);
        for (int i = 0; i < s.len(); i++) begin
            while (!chr_ready) @(negedge clk);
            chr_data = s[i];
            chr_valid = 1'b1;
            @(negedge clk);
        end
        chr_valid = 1'b0;
        chr_data = ~chr_data;
    endtask
endmodule // rms_host

// *** dv/relay_matrix_command_sequencer_bench.sv ***
// bench for the relay matrix command sequencer
`timescale 1ns/1ps
module relay_matrix_command_sequencer_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid, cmd_ready, chr_valid, chr_ready, q_valid, q_closed, scan_armed;
    logic [3:0] cmd_op;
    logic [1:0] cmd_slot;
    logic [15:0] cmd_arg;
    logic [7:0] chr_data, ttl_in, ttl_out_n, seen;
    logic [rms_pkg::RELAY_N-1:0] rc;
    logic [7:0] qlog = 8'h00;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int qn = 0;
    int n;
    always #5 clk = ~clk;
    rms_host h (.clk(clk), .cmd_ready(cmd_ready), .chr_ready(chr_ready), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_slot(cmd_slot), .cmd_arg(cmd_arg), .chr_valid(chr_valid),
        .chr_data(chr_data), .ttl_in(ttl_in));
    rms_seq #(.DWELL_UNIT_CYC(10)) dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_slot(cmd_slot), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
        .chr_valid(chr_valid), .chr_data(chr_data), .chr_ready(chr_ready), .ttl_in(ttl_in),
        .ttl_out_n(ttl_out_n), .relay_closed(rc), .q_valid(q_valid), .q_closed(q_closed),
        .scan_armed(scan_armed));
    always @(posedge clk) begin
        if (q_valid === 1'b1) begin
            qlog <= {qlog[6:0], q_closed};
            qn <= qn + 1;
        end
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_idle();
        n = 0;
        while (cmd_ready !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (cmd_ready !== 1'b1) mismatches++;
    endtask
    // n counts settle cycles, then pulse width is measured
    task automatic pulse(input logic [7:0] exp);
        n = 0;
        while (ttl_out_n === 8'hff && n < 3000) begin
            @(negedge clk);
            n++;
        end
        seen = ttl_out_n;
        for (int w = 0; w < 1000 && ttl_out_n !== 8'hff; w++) begin
            @(negedge clk);
            if (ttl_out_n === 8'hff) chk(w + 1, rms_pkg::PULSE_CYC);
        end
        chk(seen, exp);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        chk({ttl_out_n, 7'h00, scan_armed, 15'h0000, |rc}, 32'hff000000);
        h.cmd(rms_pkg::CMD_TTL_EN, 2'h0, 16'h0008);
        h.cmd(rms_pkg::CMD_CDWELL, 2'h0, 16'h0002);
        h.cmd(rms_pkg::CMD_CDWELL, 2'h1, 16'h0005);
        h.list(rms_pkg::CMD_CLOSE, "m1(2!1!1:2!4!1,3!10!2),m2(2!4)\n");
        pulse(8'hfe);
        chk(n > 49, 1'b1);
        chk({rc[20:15], rc[105], rc[275]}, 8'h7b);
        wait_idle();
        h.list(rms_pkg::CMD_QUERY, "m1(17,21,106)\n");
        wait_idle();
        chk({qn[3:0], qlog[3:0]}, 8'h35);
        h.cmd(rms_pkg::CMD_TTL_EN, 2'h0, 16'h0000);
        h.cmd(rms_pkg::CMD_TTL_EN, 2'h0, 16'h000a);
        h.list(rms_pkg::CMD_CLOSE, "m1(1)\n");
        pulse(8'hfb);
        wait_idle();
        h.cmd(rms_pkg::CMD_RESET, 2'h0, 16'h0000);
        chk(|rc, 1'b0);
        h.list(rms_pkg::CMD_SCAN, "m1(1:3)\n");
        wait_idle();
        h.cmd(rms_pkg::CMD_SRC, 2'h0, {14'h0000, rms_pkg::SRC_HOLD});
        h.cmd(rms_pkg::CMD_ARM, 2'h0, 16'h0000);
        chk(scan_armed, 1'b1);
        h.cmd(rms_pkg::CMD_TRG_BUS, 2'h0, 16'h0000);
        h.cmd(rms_pkg::CMD_TRG_COMMON, 2'h0, 16'h0000);
        wait_idle();
        chk(rc[2:0], 3'h0);
        h.cmd(rms_pkg::CMD_TRG_IMM, 2'h0, 16'h0000);
        wait_idle();
        chk(rc[2:0], 3'h1);
        h.cmd(rms_pkg::CMD_TRG_IMM, 2'h0, 16'h0000);
        wait_idle();
        chk(rc[2:0], 3'h2);
        h.cmd(rms_pkg::CMD_ABORT, 2'h0, 16'h0000);
        chk(scan_armed, 1'b0);
        h.cmd(rms_pkg::CMD_TRG_IMM, 2'h0, 16'h0000);
        wait_idle();
        chk(rc[2:0], 3'h2);
        h.cmd(rms_pkg::CMD_TDELAY, 2'h0, 16'h0003);
        h.cmd(rms_pkg::CMD_ARM, 2'h0, 16'h0000);
        h.ttl(8'hfe);
        h.ttl(8'hff);
        wait_idle();
        chk(rc[2:0], 3'h2);
        h.cmd(rms_pkg::CMD_SRC, 2'h0, {14'h0000, rms_pkg::SRC_TTL});
        h.ttl(8'hfe);
        h.ttl(8'hff);
        repeat (10) @(negedge clk);
        chk(rc[0], 1'b0);
        wait_idle();
        chk(rc[2:0], 3'h3);
        h.cmd(rms_pkg::CMD_TRG_IMM, 2'h0, 16'h0000);
        repeat (3) @(negedge clk);
        chk(rc[2:0], 3'h2);
        wait_idle();
        h.cmd(rms_pkg::CMD_SRC, 2'h0, {14'h0000, rms_pkg::SRC_BUS});
        h.cmd(rms_pkg::CMD_TRG_BUS, 2'h0, 16'h0000);
        wait_idle();
        chk(rc[2:0], 3'h4);
        h.cmd(rms_pkg::CMD_DEFINE, 2'h1, 16'h7879);
        h.list(rms_pkg::CMD_CLOSE, "xy(1)\n");
        wait_idle();
        chk(rc[256], 1'b1);
        print_verdict();
    end
endmodule // relay_matrix_command_sequencer_bench
